// ### rtl/pmux_pkg.sv
// Constants, types and carriers for the general-purpose pin multiplexer
// Function
// - Regulator enable drives pin A7 open-drain after reset
// - Debug config bit 4 releases pin A7
// - Timer one channel four needs enable and alternate
// - Timer one channels three, four read A6, A7
// - Remap bit 6 moves timer two channel three
// - Remap bit 7 moves timer two channel four
// - Remap bit 4 moves timer two channel one
// - Remap bit 5 moves timer two channel two
// - Shared pin yields to active timer channel
// - Flow-control pins need UART mode and bit 5
// - SPI bit 4 picks master or slave clocking
// - Serial two slave drives A1, reads A0
// - Serial two two-wire uses A1, A2 open-drain
// - Chip reset is active low
// - Boot strap on A5 sampled at reset release
// - Packet trace needs CPU trace off, alternate
// - Trace bits two, three need four-wire trace
// - Trace clock needs trace, free channel, alternate
// - Analog field connects analog inputs four, five
// - Port A low fields hold pins zero to three
// - Serial pins follow written operating mode only
package pmux_pkg;
  localparam int FIELD_W = 4;
  localparam logic [3:0] CFG_ANALOG = 4'h0;
  localparam logic [3:0] CFG_GP_OUT = 4'h1;
  localparam logic [3:0] CFG_GP_OD = 4'h5;
  localparam logic [3:0] CFG_INPUT = 4'h4;
  localparam logic [3:0] CFG_INPUT_PULL = 4'h8;
  localparam logic [3:0] CFG_ALT_OUT = 4'h9;
  localparam logic [3:0] CFG_ALT_OD = 4'hD;
  localparam int PA_FIELD_LSB [0:7] = '{0, 4, 8, 12, 0, 4, 8, 12};
  localparam int PB_FIELD_LSB [1:4] = '{4, 8, 12, 0};
  localparam int DBG_REG_EN_RELEASE = 4;
  localparam int T1_CH3_OE = 8;
  localparam int T1_CH4_OE = 12;
  localparam int T2_CH_OE [0:3] = '{0, 4, 8, 12};
  localparam int T2_REMAP [0:3] = '{4, 5, 6, 7};
  localparam int UART_FLOW_BIT = 5;
  localparam int SPI_MASTER_BIT = 4;
  localparam logic PIN_RESET_OUT = 1'b0;
  localparam logic PIN_RESET_OE_N = 1'b1;
  localparam logic SYNC_RESET = 1'b1;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BOOT_SAMPLE_NS = 100;
  localparam int BOOT_SAMPLE_CYCLES =
    (BOOT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_UART = 2'h1,
    MODE_SPI = 2'h2,
    MODE_TWI = 2'h3
  } serial_mode_t;

  typedef enum logic [1:0] {
    BOOT_SAMPLE = 2'h1,
    BOOT_DONE = 2'h2
  } boot_state_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic [15:0] pa_low;
    logic [15:0] pa_high;
    logic [15:0] pb_low;
    logic [15:0] pb_high;
  } port_config_t;

  typedef struct packed {
    logic enable;
    logic four_wire;
  } trace_ctrl_t;
endpackage : pmux_pkg

// ### rtl/boot_strap_capture.sv
// Boot strap capture window after chip reset release
`timescale 1ns/1ps
module boot_strap_capture #(
  parameter int SAMPLE_CYCLES = pmux_pkg::BOOT_SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Strap
  input wire logic strap_n,
  output logic sampling,
  output logic factory_monitor
);
  pmux_pkg::boot_state_t state;
  logic [7:0] count;

  assign sampling = (state == pmux_pkg::BOOT_SAMPLE);

  // Window is open from reset until SAMPLE_CYCLES cycles after release; flops may not load ports in reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmux_pkg::BOOT_SAMPLE;
      count <= 8'h00;
    end else if (ce) begin
      unique case (state)
        pmux_pkg::BOOT_SAMPLE: begin
          if (count == 8'(SAMPLE_CYCLES - 1)) begin
            state <= pmux_pkg::BOOT_DONE;
          end
          count <= count + 8'h01;
        end
        pmux_pkg::BOOT_DONE: begin
          count <= count;
        end
        default: begin
          state <= pmux_pkg::BOOT_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      factory_monitor <= 1'b0;
    end else if (ce && sampling && !strap_n) begin
      factory_monitor <= 1'b1;
    end
  end

  sequence s_strap_low;
    ce && sampling && !strap_n;
  endsequence

  sequence s_window_over;
    ce && state == pmux_pkg::BOOT_DONE;
  endsequence

  a_boot_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    s_strap_low |=> factory_monitor)
    else $error("strap low in window not captured");

  a_monitor_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    s_window_over |=> $stable(factory_monitor) && !sampling)
    else $error("monitor select changed after window");
endmodule : boot_strap_capture

// ### rtl/pin_function_mux.sv
// Pin-function multiplexer for port A and port B shared pins
`timescale 1ns/1ps
module pin_function_mux (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // Configuration
  input wire pmux_pkg::port_config_t port_config,
  input wire logic [7:0] debug_pin_config,
  input wire logic [15:0] timer_one_output_enable,
  input wire logic [15:0] timer_two_output_enable,
  input wire logic [7:0] timer_two_remap_bits,
  input wire logic [7:0] serial1_uart_config,
  input wire logic [7:0] serial1_spi_config,
  input wire logic [7:0] serial2_spi_config,
  input wire pmux_pkg::serial_mode_t serial1_mode_select,
  input wire pmux_pkg::serial_mode_t serial2_mode_select,
  input wire pmux_pkg::trace_ctrl_t trace_ctrl,
  input wire logic regulator_on,
  // Port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_n,
  // Port B pins 1 to 4
  input wire logic [4:1] pb_in,
  output logic [4:1] pb_out,
  output logic [4:1] pb_oe_n,
  // General-purpose I/O logic
  input wire logic [7:0] gpio_a_out,
  input wire logic [4:1] gpio_b_out,
  output logic [7:0] gpio_a_in,
  output logic [4:1] gpio_b_in,
  // Timers
  input wire logic timer_one_channel_three,
  input wire logic timer_one_channel_four,
  input wire logic [3:0] timer_two_channel_out,
  output logic timer_one_channel_three_in,
  output logic timer_one_channel_four_in,
  output logic [3:0] timer_two_channel_in,
  // Serial controller 1
  input wire logic serial1_data_out,
  input wire logic serial1_spi_clock,
  input wire logic serial1_request_to_send_n,
  input wire logic serial1_twowire_data_out,
  input wire logic serial1_twowire_clock_out,
  output logic serial1_data_in,
  output logic serial1_spi_clock_in,
  output logic serial1_slave_select_n,
  output logic serial1_clear_to_send_n,
  output logic serial1_twowire_data_in,
  output logic serial1_twowire_clock_in,
  // Serial controller 2
  input wire logic serial2_master_out,
  input wire logic serial2_master_in,
  input wire logic serial2_spi_clock,
  input wire logic serial2_twowire_data,
  input wire logic serial2_twowire_clock,
  output logic serial2_data_in,
  output logic serial2_spi_clock_in,
  output logic serial2_slave_select_n,
  output logic serial2_twowire_data_in,
  output logic serial2_twowire_clock_in,
  // Trace sources
  input wire logic cpu_trace_clock,
  input wire logic cpu_trace_bit_two,
  input wire logic cpu_trace_bit_three,
  input wire logic packet_trace_frame,
  input wire logic packet_trace_serial_out,
  // Analog and boot
  output logic analog_input_four,
  output logic analog_input_five,
  output logic factory_monitor
);
  logic [7:0] pa_meta;
  logic [7:0] pa_sync;
  logic [4:1] pb_meta;
  logic [4:1] pb_sync;
  logic [7:0][3:0] pa_field;
  logic [4:1][3:0] pb_field;
  logic [3:0] t2_oe;
  logic [3:0] remap;
  logic [3:0] t2_on_a;
  logic [3:0] t2_on_b;
  logic [7:0] pa_alt_v;
  logic [7:0] pa_alt_en;
  logic [4:1] pb_alt_v;
  logic [4:1] pb_alt_en;
  pmux_pkg::pin_drive_t [7:0] next_pa;
  pmux_pkg::pin_drive_t [4:1] next_pb;
  logic s1_uart;
  logic s1_flow;
  logic s1_spi;
  logic s1_master;
  logic s1_slave;
  logic s1_twi;
  logic s2_master;
  logic s2_slave;
  logic s2_twi;
  logic boot_sampling;

  function automatic logic [3:0] cfg_field(input logic [15:0] r,
                                           input int lsb);
    return r[lsb +: pmux_pkg::FIELD_W];
  endfunction : cfg_field

  function automatic pmux_pkg::pin_drive_t drive(input logic v,
                                                 input logic od);
    pmux_pkg::pin_drive_t d;
    if (od) begin
      d = '{out: 1'b0, oe_n: v};
    end else begin
      d = '{out: v, oe_n: 1'b0};
    end
    return d;
  endfunction : drive

  // Alternate without a live source releases the pin rather than glitch
  function automatic pmux_pkg::pin_drive_t resolve(input logic [3:0] f,
    input logic alt_v, input logic alt_en, input logic gp_v);
    pmux_pkg::pin_drive_t d;
    d = '{out: pmux_pkg::PIN_RESET_OUT, oe_n: pmux_pkg::PIN_RESET_OE_N};
    if (f == pmux_pkg::CFG_ALT_OUT || f == pmux_pkg::CFG_ALT_OD) begin
      if (alt_en) begin
        d = drive(alt_v, f == pmux_pkg::CFG_ALT_OD);
      end
    end else if (f == pmux_pkg::CFG_GP_OUT || f == pmux_pkg::CFG_GP_OD) begin
      d = drive(gp_v, f == pmux_pkg::CFG_GP_OD);
    end
    return d;
  endfunction : resolve

  // Two-flop pin synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_meta <= {8{pmux_pkg::SYNC_RESET}};
      pa_sync <= {8{pmux_pkg::SYNC_RESET}};
      pb_meta <= {4{pmux_pkg::SYNC_RESET}};
      pb_sync <= {4{pmux_pkg::SYNC_RESET}};
    end else if (ce) begin
      pa_meta <= pa_in;
      pa_sync <= pa_meta;
      pb_meta <= pb_in;
      pb_sync <= pb_meta;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_field[i] = cfg_field(i < 4 ? port_config.pa_low
                              : port_config.pa_high,
                              pmux_pkg::PA_FIELD_LSB[i]);
    end
    for (int i = 1; i < 4; i++) begin
      pb_field[i] = cfg_field(port_config.pb_low, pmux_pkg::PB_FIELD_LSB[i]);
    end
    pb_field[4] = cfg_field(port_config.pb_high, pmux_pkg::PB_FIELD_LSB[4]);
    for (int c = 0; c < 4; c++) begin
      t2_oe[c] = timer_two_output_enable[pmux_pkg::T2_CH_OE[c]];
      remap[c] = timer_two_remap_bits[pmux_pkg::T2_REMAP[c]];
    end
    t2_on_a = t2_oe & ~remap;
    t2_on_b = t2_oe & remap;
  end

  // Serial pins follow only the mode written last, as the final step
  assign s1_uart = serial1_mode_select == pmux_pkg::MODE_UART;
  assign s1_flow = s1_uart && serial1_uart_config[pmux_pkg::UART_FLOW_BIT];
  assign s1_spi = serial1_mode_select == pmux_pkg::MODE_SPI;
  assign s1_master = s1_spi && serial1_spi_config[pmux_pkg::SPI_MASTER_BIT];
  assign s1_slave = s1_spi && !serial1_spi_config[pmux_pkg::SPI_MASTER_BIT];
  assign s1_twi = serial1_mode_select == pmux_pkg::MODE_TWI;
  assign s2_master = serial2_mode_select == pmux_pkg::MODE_SPI &&
                     serial2_spi_config[pmux_pkg::SPI_MASTER_BIT];
  assign s2_slave = serial2_mode_select == pmux_pkg::MODE_SPI &&
                    !serial2_spi_config[pmux_pkg::SPI_MASTER_BIT];
  assign s2_twi = serial2_mode_select == pmux_pkg::MODE_TWI;

  // Timer channels win their pin; controllers take what is left
  always_comb begin
    pa_alt_v = 8'h00;
    pa_alt_en = 8'h00;
    pb_alt_v = 4'h0;
    pb_alt_en = 4'h0;
    if (t2_on_a[0]) begin
      pa_alt_v[0] = timer_two_channel_out[0];
      pa_alt_en[0] = 1'b1;
    end else if (s2_master) begin
      pa_alt_v[0] = serial2_master_out;
      pa_alt_en[0] = 1'b1;
    end
    if (t2_on_a[2]) begin
      pa_alt_v[1] = timer_two_channel_out[2];
      pa_alt_en[1] = 1'b1;
    end else if (s2_twi) begin
      pa_alt_v[1] = serial2_twowire_data;
      pa_alt_en[1] = 1'b1;
    end else if (s2_slave) begin
      pa_alt_v[1] = serial2_master_in;
      pa_alt_en[1] = 1'b1;
    end
    if (t2_on_a[3]) begin
      pa_alt_v[2] = timer_two_channel_out[3];
      pa_alt_en[2] = 1'b1;
    end else if (s2_twi) begin
      pa_alt_v[2] = serial2_twowire_clock;
      pa_alt_en[2] = 1'b1;
    end else if (s2_master) begin
      pa_alt_v[2] = serial2_spi_clock;
      pa_alt_en[2] = 1'b1;
    end
    if (t2_on_a[1]) begin
      pa_alt_v[3] = timer_two_channel_out[1];
      pa_alt_en[3] = 1'b1;
    end else if (trace_ctrl.enable) begin
      pa_alt_v[3] = cpu_trace_clock;
      pa_alt_en[3] = 1'b1;
    end
    if (trace_ctrl.enable) begin
      pa_alt_v[4] = cpu_trace_bit_two;
      pa_alt_v[5] = cpu_trace_bit_three;
      pa_alt_en[4] = trace_ctrl.four_wire;
      pa_alt_en[5] = trace_ctrl.four_wire;
    end else begin
      pa_alt_v[4] = packet_trace_frame;
      pa_alt_v[5] = packet_trace_serial_out;
      pa_alt_en[4] = 1'b1;
      pa_alt_en[5] = 1'b1;
    end
    pa_alt_v[6] = timer_one_channel_three;
    pa_alt_en[6] = timer_one_output_enable[pmux_pkg::T1_CH3_OE];
    pa_alt_v[7] = timer_one_channel_four;
    pa_alt_en[7] = timer_one_output_enable[pmux_pkg::T1_CH4_OE];
    if (t2_on_b[0]) begin
      pb_alt_v[1] = timer_two_channel_out[0];
      pb_alt_en[1] = 1'b1;
    end else if (s1_twi) begin
      pb_alt_v[1] = serial1_twowire_data_out;
      pb_alt_en[1] = 1'b1;
    end else if (s1_uart || s1_spi) begin
      pb_alt_v[1] = serial1_data_out;
      pb_alt_en[1] = 1'b1;
    end
    if (t2_on_b[1]) begin
      pb_alt_v[2] = timer_two_channel_out[1];
      pb_alt_en[2] = 1'b1;
    end else if (s1_twi) begin
      pb_alt_v[2] = serial1_twowire_clock_out;
      pb_alt_en[2] = 1'b1;
    end
    if (t2_on_b[2]) begin
      pb_alt_v[3] = timer_two_channel_out[2];
      pb_alt_en[3] = 1'b1;
    end else if (s1_master) begin
      pb_alt_v[3] = serial1_spi_clock;
      pb_alt_en[3] = 1'b1;
    end
    if (t2_on_b[3]) begin
      pb_alt_v[4] = timer_two_channel_out[3];
      pb_alt_en[4] = 1'b1;
    end else if (s1_flow) begin
      pb_alt_v[4] = serial1_request_to_send_n;
      pb_alt_en[4] = 1'b1;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_pa[i] = resolve(pa_field[i], pa_alt_v[i], pa_alt_en[i],
                           gpio_a_out[i]);
    end
    for (int i = 1; i < 5; i++) begin
      next_pb[i] = resolve(pb_field[i], pb_alt_v[i], pb_alt_en[i],
                           gpio_b_out[i]);
    end
    if (!debug_pin_config[pmux_pkg::DBG_REG_EN_RELEASE]) begin
      next_pa[7] = drive(regulator_on, 1'b1);
    end
    if (boot_sampling) begin
      next_pa[5] = '{out: pmux_pkg::PIN_RESET_OUT,
                     oe_n: pmux_pkg::PIN_RESET_OE_N};
    end
  end

  // Pins released in reset so the strap and pull-ups settle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_out <= {8{pmux_pkg::PIN_RESET_OUT}};
      pa_oe_n <= {8{pmux_pkg::PIN_RESET_OE_N}};
      pb_out <= {4{pmux_pkg::PIN_RESET_OUT}};
      pb_oe_n <= {4{pmux_pkg::PIN_RESET_OE_N}};
    end else if (ce) begin
      for (int i = 0; i < 8; i++) begin
        pa_out[i] <= next_pa[i].out;
        pa_oe_n[i] <= next_pa[i].oe_n;
      end
      for (int i = 1; i < 5; i++) begin
        pb_out[i] <= next_pb[i].out;
        pb_oe_n[i] <= next_pb[i].oe_n;
      end
    end
  end

  // Inputs to timers and general I/O
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_a_in <= 8'hFF;
      gpio_b_in <= 4'hF;
      timer_one_channel_three_in <= 1'b0;
      timer_one_channel_four_in <= 1'b0;
      timer_two_channel_in <= 4'h0;
      analog_input_four <= 1'b0;
      analog_input_five <= 1'b0;
    end else if (ce) begin
      gpio_a_in <= pa_sync;
      gpio_b_in <= pb_sync;
      timer_one_channel_three_in <= pa_sync[6];
      timer_one_channel_four_in <= pa_sync[7];
      timer_two_channel_in[0] <= remap[0] ? pb_sync[1] : pa_sync[0];
      timer_two_channel_in[1] <= remap[1] ? pb_sync[2] : pa_sync[3];
      timer_two_channel_in[2] <= remap[2] ? pb_sync[3] : pa_sync[1];
      timer_two_channel_in[3] <= remap[3] ? pb_sync[4] : pa_sync[2];
      analog_input_four <= pa_field[4] == pmux_pkg::CFG_ANALOG;
      analog_input_five <= pa_field[5] == pmux_pkg::CFG_ANALOG;
    end
  end

  // Serial inputs idle at their inactive level when not routed, except clear to send, which is held low (asserted)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial1_data_in <= 1'b1;
      serial1_spi_clock_in <= 1'b0;
      serial1_slave_select_n <= 1'b1;
      serial1_clear_to_send_n <= 1'b0;
      serial1_twowire_data_in <= 1'b1;
      serial1_twowire_clock_in <= 1'b1;
      serial2_data_in <= 1'b1;
      serial2_spi_clock_in <= 1'b0;
      serial2_slave_select_n <= 1'b1;
      serial2_twowire_data_in <= 1'b1;
      serial2_twowire_clock_in <= 1'b1;
    end else if (ce) begin
      serial1_data_in <= (s1_uart || s1_spi) ? pb_sync[2] : 1'b1;
      serial1_spi_clock_in <= s1_slave ? pb_sync[3] : 1'b0;
      serial1_slave_select_n <= s1_slave ? pb_sync[4] : 1'b1;
      serial1_clear_to_send_n <= s1_flow ? pb_sync[3] : 1'b0;
      serial1_twowire_data_in <= s1_twi ? pb_sync[1] : 1'b1;
      serial1_twowire_clock_in <= s1_twi ? pb_sync[2] : 1'b1;
      serial2_data_in <= s2_slave ? pa_sync[0]
                         : (s2_master ? pa_sync[1] : 1'b1);
      serial2_spi_clock_in <= s2_slave ? pa_sync[2] : 1'b0;
      serial2_slave_select_n <= s2_slave ? pa_sync[3] : 1'b1;
      serial2_twowire_data_in <= s2_twi ? pa_sync[1] : 1'b1;
      serial2_twowire_clock_in <= s2_twi ? pa_sync[2] : 1'b1;
    end
  end

  boot_strap_capture #(
    .SAMPLE_CYCLES(pmux_pkg::BOOT_SAMPLE_CYCLES)
  ) u_boot (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .strap_n(pa_sync[5]),
    .sampling(boot_sampling),
    .factory_monitor(factory_monitor)
  );

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_reg_en_override: assert property (
    ce && !debug_pin_config[pmux_pkg::DBG_REG_EN_RELEASE]
    |=> !pa_out[7] && pa_oe_n[7] == $past(regulator_on))
    else $error("regulator enable not open-drain on A7");

  a_reg_en_release: assert property (
    ce && debug_pin_config[pmux_pkg::DBG_REG_EN_RELEASE] &&
    pa_field[7] == pmux_pkg::CFG_GP_OUT
    |=> !pa_oe_n[7] && pa_out[7] == $past(gpio_a_out[7]))
    else $error("A7 not released to general output");

  a_timer_one_four: assert property (
    ce && debug_pin_config[pmux_pkg::DBG_REG_EN_RELEASE] &&
    pa_field[7] == pmux_pkg::CFG_ALT_OUT &&
    !timer_one_output_enable[pmux_pkg::T1_CH4_OE] |=> pa_oe_n[7])
    else $error("timer one channel four drove while disabled");

  a_timer_one_in: assert property (
    ce ##1 ce ##1 ce |=> timer_one_channel_four_in == $past(pa_in[7], 3))
    else $error("timer one channel four input not from A7");

  a_remap_three: assert property (
    ce && remap[2] |=> timer_two_channel_in[2] == $past(pb_sync[3]))
    else $error("remapped channel three input wrong pin");

  a_shared_guard: assert property (
    ce && t2_on_a[0] && pa_field[0] == pmux_pkg::CFG_ALT_OUT
    |=> pa_out[0] == $past(timer_two_channel_out[0]) && !pa_oe_n[0])
    else $error("controller took A0 from active timer");

  a_cts_gate: assert property (
    ce && !s1_flow |=> !serial1_clear_to_send_n)
    else $error("clear to send passed without flow control");

  a_spi2_slave: assert property (
    ce && s2_slave |=> serial2_data_in == $past(pa_sync[0]))
    else $error("slave data not taken from A0");

  a_twowire_od: assert property (
    ce && s2_twi && !t2_on_a[2] && pa_field[1] == pmux_pkg::CFG_ALT_OD
    |=> !pa_out[1] && pa_oe_n[1] == $past(serial2_twowire_data))
    else $error("two-wire data not open-drain on A1");

  a_pti_blocked: assert property (
    ce && trace_ctrl.enable && !trace_ctrl.four_wire &&
    pa_field[4] == pmux_pkg::CFG_ALT_OUT |=> pa_oe_n[4])
    else $error("A4 driven with trace on and not four-wire");

  a_trace_clock: assert property (
    ce && !trace_ctrl.enable && !t2_on_a[1] &&
    pa_field[3] == pmux_pkg::CFG_ALT_OUT |=> pa_oe_n[3])
    else $error("trace clock driven while trace off");

  a_analog_four: assert property (
    ce && pa_field[4] == pmux_pkg::CFG_ANALOG |=> analog_input_four)
    else $error("analog input four not connected");
endmodule : pin_function_mux

// ### bench/board_pins.sv
// Board-side pin model: pull-ups and external drivers
`timescale 1ns/1ps
module board_pins #(
  parameter int W = 8
) (
  // Device drive
  input wire logic [W-1:0] dev_out,
  input wire logic [W-1:0] dev_oe_n,
  // External drive
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // Pin level
  output logic [W-1:0] level
);
  // Released pins read the external driver if enabled, else the pull-up, so no unknown reaches the device
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!dev_oe_n[i]) level[i] = dev_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else level[i] = 1'b1;
    end
  end
endmodule : board_pins

// ### bench/tb_pin_function_mux.sv
// Self-checking bench for the pin-function multiplexer
`timescale 1ns/1ps
module tb_pin_function_mux;
  logic mclk = 0, rst_n = 0, ce = 1, regulator_on = 0;
  pmux_pkg::port_config_t port_config;
  pmux_pkg::serial_mode_t serial1_mode_select, serial2_mode_select;
  pmux_pkg::trace_ctrl_t trace_ctrl;
  logic [7:0] debug_pin_config, timer_two_remap_bits, serial1_uart_config;
  logic [7:0] serial1_spi_config, serial2_spi_config, pa_in, pa_out, pa_oe_n;
  logic [7:0] gpio_a_out, gpio_a_in, pa_ext, pa_en;
  logic [15:0] timer_one_output_enable, timer_two_output_enable;
  logic [4:1] pb_in, pb_out, pb_oe_n, gpio_b_out, gpio_b_in, pb_ext, pb_en;
  logic [3:0] timer_two_channel_out, timer_two_channel_in;
  logic timer_one_channel_three, timer_one_channel_four;
  logic timer_one_channel_three_in, timer_one_channel_four_in;
  logic serial1_data_out, serial1_spi_clock, serial1_request_to_send_n;
  logic serial1_twowire_data_out, serial1_twowire_clock_out, serial1_data_in;
  logic serial1_spi_clock_in, serial1_slave_select_n, serial1_clear_to_send_n;
  logic serial1_twowire_data_in, serial1_twowire_clock_in, serial2_master_out;
  logic serial2_master_in, serial2_spi_clock, serial2_twowire_data;
  logic serial2_twowire_clock, serial2_data_in, serial2_spi_clock_in;
  logic serial2_slave_select_n, serial2_twowire_data_in;
  logic serial2_twowire_clock_in, cpu_trace_clock, cpu_trace_bit_two;
  logic cpu_trace_bit_three, packet_trace_frame, packet_trace_serial_out;
  logic analog_input_four, analog_input_five, factory_monitor;
  logic [1:0] e, g;
  int fails = 0, cmp_count = 0;

  pin_function_mux pin_function_mux_i (.*);
  board_pins #(.W(8)) board_pins_i (.dev_out(pa_out), .dev_oe_n(pa_oe_n),
    .ext_val(pa_ext), .ext_en(pa_en), .level(pa_in));
  board_pins #(.W(4)) board_pins_b_i (.dev_out(pb_out), .dev_oe_n(pb_oe_n),
    .ext_val(pb_ext), .ext_en(pb_en), .level(pb_in));

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step

  task automatic note(input string s);
    $display("end of %s", s);
  endtask : note

  task automatic shake();
    {timer_one_channel_three, timer_one_channel_four, timer_two_channel_out,
     serial1_data_out, serial1_spi_clock, serial1_request_to_send_n,
     serial1_twowire_data_out, serial1_twowire_clock_out, serial2_master_out,
     serial2_master_in, serial2_spi_clock, serial2_twowire_data,
     serial2_twowire_clock, cpu_trace_clock, cpu_trace_bit_two,
     cpu_trace_bit_three, packet_trace_frame, packet_trace_serial_out,
     gpio_a_out, gpio_b_out} = 33'({$urandom, $urandom});
  endtask : shake

  task automatic test_done();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Pin index 0..3 is A0..A3, 4..7 is B1..B4; result is {out, oe_n}
  function automatic logic [1:0] exp_pin(input int p);
    int c;
    logic m;
    c = p < 4 ? (p == 0 ? 0 : (p == 3 ? 1 : p + 1)) : p - 4;
    m = serial2_spi_config[4];
    if (timer_two_output_enable[4*c] && (timer_two_remap_bits[4+c] == (p > 3)))
      return {timer_two_channel_out[c], 1'b0};
    if (p == 0 && m) return {serial2_master_out, 1'b0};
    if (p == 1 && !m) return {serial2_master_in, 1'b0};
    if (p == 2 && m) return {serial2_spi_clock, 1'b0};
    return 2'b01;
  endfunction : exp_pin

  initial begin
    #2000000;
    fails++;
    test_done();
  end

  initial begin
    void'($urandom(84947));
    {debug_pin_config, timer_two_remap_bits, serial1_uart_config,
     serial1_spi_config, serial2_spi_config, timer_one_output_enable,
     timer_two_output_enable, trace_ctrl, pb_ext, pb_en} = '0;
    port_config = '0;
    serial1_mode_select = pmux_pkg::MODE_OFF;
    serial2_mode_select = pmux_pkg::MODE_OFF;
    pa_ext = 8'h00;
    pa_en = 8'h60;
    shake();
    step(2);
    chk(pa_oe_n, 8'hFF);
    step(2);
    rst_n = 1;
    step(6);
    chk(factory_monitor, 1'b1);
    chk({pa_oe_n[7], pa_out[7]}, 2'b00);
    pa_ext = 8'hFF;
    regulator_on = 1;
    step(1);
    chk(pa_oe_n[7], 1'b1);
    regulator_on = 0;
    debug_pin_config = 8'h10;
    port_config.pa_high = 16'h9000;
    for (int k = 0; k < 4; k++) begin
      timer_one_output_enable = k[0] ? 16'h1000 : 16'h0000;
      shake();
      step(1);
      chk(pa_oe_n[7], !k[0]);
      if (k[0]) chk(pa_out[7], timer_one_channel_four);
    end
    note("release");
    // Pins read back only after the two-stage synchroniser
    port_config.pa_high = 16'h4400;
    pa_en = 8'hC0;
    for (int k = 0; k < 4; k++) begin
      pa_ext = {k[1:0], 6'h3F};
      step(4);
      chk({timer_one_channel_four_in, timer_one_channel_three_in}, k[1:0]);
      chk(gpio_a_in[7:6], k[1:0]);
    end
    pa_en = 8'h00;
    port_config.pa_high = 16'h1110;
    shake();
    step(1);
    chk({pa_oe_n[7:5], pa_out[7:5]}, {3'b000, gpio_a_out[7:5]});
    chk({analog_input_five, analog_input_four}, 2'b01);
    note("timer one");
    port_config.pa_high = 16'h0099;
    for (int k = 0; k < 4; k++) begin
      trace_ctrl = 2'(k);
      shake();
      step(1);
      e = trace_ctrl.enable ? {cpu_trace_bit_three, cpu_trace_bit_two} :
        {packet_trace_serial_out, packet_trace_frame};
      chk({pa_oe_n[5:4], pa_out[5:4]}, k == 2 ? 4'hC : {2'b00, e});
      chk(analog_input_four, 1'b0);
    end
    trace_ctrl = 2'b00;
    note("trace");
    port_config = '{16'h9999, 16'h0000, 16'h9990, 16'h0009};
    serial2_mode_select = pmux_pkg::MODE_SPI;
    for (int n = 0; n < 48; n++) begin
      timer_two_remap_bits = 8'($urandom);
      timer_two_output_enable = 16'($urandom);
      serial2_spi_config = 8'($urandom);
      shake();
      step(1);
      for (int p = 0; p < 8; p++) begin
        e = exp_pin(p);
        g = p < 4 ? {pa_out[p], pa_oe_n[p]} : {pb_out[p-3], pb_oe_n[p-3]};
        chk(g[0], e[0]);
        if (!e[0]) chk(g[1], e[1]);
      end
    end
    note("remap");
    serial2_mode_select = pmux_pkg::MODE_OFF;
    serial1_mode_select = pmux_pkg::MODE_UART;
    timer_two_output_enable = 16'h0000;
    port_config.pb_low = 16'h4000;
    pb_en = 4'b0100;
    for (int k = 0; k < 4; k++) begin
      serial1_uart_config = k[1] ? 8'h20 : 8'h00;
      pb_ext = {1'b0, k[0], 2'b00};
      shake();
      step(4);
      chk(serial1_clear_to_send_n, k[1] & k[0]);
      chk({gpio_b_in[3], serial1_data_in}, {k[0], 1'b1});
      e = {1'b0, serial1_request_to_send_n};
      if (k[1]) chk({pb_oe_n[4], pb_out[4]}, e);
    end
    note("flow control");
    serial1_mode_select = pmux_pkg::MODE_TWI;
    serial2_mode_select = pmux_pkg::MODE_TWI;
    port_config = '{16'h0DD0, 16'h0000, 16'h0DD0, 16'h0009};
    shake();
    step(1);
    e = {serial2_twowire_clock, serial2_twowire_data};
    g = {serial1_twowire_clock_out, serial1_twowire_data_out};
    chk({pa_oe_n[2:1], pa_out[2:1]}, {e, 2'b00});
    chk({pb_oe_n[2:1], pb_out[2:1]}, {g, 2'b00});
    step(3);
    chk({serial2_twowire_clock_in, serial2_twowire_data_in}, e);
    chk({serial1_twowire_clock_in, serial1_twowire_data_in}, g);
    note("two-wire");
    // Second reset with the strap high must not start the monitor
    rst_n = 0;
    pa_en = 8'h20;
    step(1);
    chk(pa_oe_n, 8'hFF);
    rst_n = 1;
    step(6);
    chk(factory_monitor, 1'b0);
    note("second reset");
    test_done();
  end
endmodule : tb_pin_function_mux
